//--- rtl/sys_io_power_control.sv
// system-tool logic: power, busy gating, aux lines, tests, id registers
// assumes frames arrive whole and synchronous; capture engine is external
//
// Overview of operation
// R1: global command bit 1 enters sleep
// R2: record control bit 7 auto sleeps after record
// R3: chip-select falling edge wakes to idle
// R4: trigger-line toggle also wakes device
// R5: stays awake after record without auto sleep
// R6: busy accepts only status read and escape
// R7: status bit 7 low busy, high ready
// R8: escape aborts only an ongoing capture
// R9: host repeats escape while polling busy
// R10: busy line active while busy; line one default
// R11: trigger high 2.6 us, record on fall
// R12: alarm line active on any flag 13:8
// R13: split mode: line two level 2, one level 1
// R14: clear-flags command releases alarm lines
// R15: config 5:4 line two, 3:2 line one function
// R16: config bits 1:0 set line polarity
// R17: io control sets direction, level, reports input
// R18: global bit 2 self-test, result status bit 5
// R19: global bit 5 flash check, result status bit 6
// R20: flash counter counts each flash write
// R21: serial and lot codes are 16-bit read-only
// R22: owner tag writable, readable, reset zero
// R23: command bits self-clear when done
// R24: error flags sticky until clear or record
// R25: byte write frame: flag, address, data
// R26: trigger ignored while already busy
`timescale 1ns/10ps
module sys_io_power_control
   import sys_io_pkg::*;
#(
   parameter int             SELF_CYC   = SELF_TEST_CYC,
   parameter int             FLASH_CYC  = FLASH_TEST_CYC,
   parameter logic [15:0]    LOT_FIRST  = 16'h0001, // arbitrary value
   parameter logic [15:0]    LOT_SECOND = 16'h0002, // arbitrary value
   parameter logic [15:0]    PART_CODE  = 16'h1234, // arbitrary value
   parameter logic [15:0]    SERIAL     = 16'h0003  // arbitrary value
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         cs_n_i,
   input  wire logic         frame_valid_i,
   input  wire frame_t       frame_i,
   output logic [15:0]       rdata_o,
   output logic              rdata_valid_o,
   input  wire logic         capture_busy_i,
   input  wire logic         record_done_i,
   output logic              record_start_o,
   output logic              capture_abort_o,
   input  wire logic [5:0]   alarm_set_i,
   input  wire logic         flash_write_i,
   input  wire logic         self_test_fail_i,
   input  wire logic         flash_sum_fail_i,
   input  wire logic [1:0]   line_in_i,
   output logic [1:0]        line_o,
   output logic [1:0]        line_oe_o,
   output logic              sleep_o
);
   // ***************************************************
   // registers
   // ***************************************************
   logic [15:0] line_cfg_q, line_io_q, owner_q, flash_write_counter_q, alarm_ctrl_q, rec_ctrl_q;
   logic [15:0] diag_q;
   logic [15:0] glob_q;
   logic [31:0] cmd_cnt_q;
   logic        sleep_q, cs_n_q;
   logic [1:0]  line_in_q;
   logic [15:0] trig_cnt_q [2];
   logic        busy, gated, accept, is_write, trig_fire, trig_wake;
   logic [1:0]  fire;
   logic [15:0] rd_mux;
   line_drive_t drv;

   // busy covers capture and any running command
   assign busy   = capture_busy_i || (glob_q != 16'h0000);
   assign gated  = frame_valid_i && !sleep_q;
   // while busy only status read and escape pass
   assign accept = gated && (!busy || frame_i == DIAG_READ_FRAME || frame_i == ESCAPE_FRAME); // R6
   assign is_write = accept && frame_i.wr; // R25

   // function of one line from its config field
   function automatic logic [1:0] line_fn(input logic [15:0] cfg, input int idx);
      return idx == 0 ? cfg[3:2] : cfg[5:4]; // R15
   endfunction

   // ***************************************************
   // trigger detection with minimum pulse width
   // ***************************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         line_in_q     <= 2'b00;
         trig_cnt_q[0] <= 16'h0000;
         trig_cnt_q[1] <= 16'h0000;
      end else begin
         line_in_q <= line_in_i;
         for (int i = 0; i < 2; i++) begin
            // count active-level width of the pulse
            if (line_in_i[i] == line_cfg_q[i])
               trig_cnt_q[i] <= (trig_cnt_q[i] == 16'hffff) ? trig_cnt_q[i] : trig_cnt_q[i] + 16'h0001;
            else
               trig_cnt_q[i] <= 16'h0000;
         end
      end
   end

   // falling edge of an accepted-width pulse
   always_comb begin
      fire      = 2'b00;
      trig_wake = 1'b0;
      for (int i = 0; i < 2; i++) begin
         if (line_fn(line_cfg_q, i) == FN_TRIG) begin
            if (line_in_q[i] != line_in_i[i])
               trig_wake = 1'b1; // R4
            if (line_in_q[i] == line_cfg_q[i] && line_in_i[i] != line_cfg_q[i]
                && trig_cnt_q[i] >= 16'(TRIG_MIN_CYC))
               fire[i] = 1'b1; // R11
         end
      end
   end
   assign trig_fire = (fire != 2'b00) && !busy && !sleep_q; // R26

   // ***************************************************
   // sleep state
   // ***************************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sleep_q <= 1'b0;
         cs_n_q  <= 1'b1;
      end else begin
         cs_n_q <= cs_n_i;
         if (sleep_q && ((cs_n_q && !cs_n_i) || trig_wake))
            sleep_q <= 1'b0; // R3
         else if (is_write && frame_i.addr == ADDR_GLOB && frame_i.data[GC_POWER_DOWN])
            sleep_q <= 1'b1; // R1
         else if (record_done_i && rec_ctrl_q[REC_AUTO_PD])
            sleep_q <= 1'b1; // R2
         // otherwise stay awake after a record R5
      end
   end

   // ***************************************************
   // global commands, self clearing
   // ***************************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         glob_q    <= 16'h0000;
         cmd_cnt_q <= 32'h0000_0000;
      end else if (glob_q != 16'h0000) begin
         cmd_cnt_q <= cmd_cnt_q - 32'h0000_0001;
         if (cmd_cnt_q == 32'h0000_0000)
            glob_q <= 16'h0000; // R23
      end else if (is_write && frame_i.addr == ADDR_GLOB) begin
         glob_q[GC_SELF_TEST]  <= frame_i.data[GC_SELF_TEST];
         glob_q[GC_CLEAR_DIAG] <= frame_i.data[GC_CLEAR_DIAG];
         glob_q[GC_FLASH_TEST] <= frame_i.data[GC_FLASH_TEST];
         if (frame_i.data[GC_SELF_TEST])
            cmd_cnt_q <= 32'(SELF_CYC - 1);
         else if (frame_i.data[GC_FLASH_TEST])
            cmd_cnt_q <= 32'(FLASH_CYC - 1);
         else
            cmd_cnt_q <= 32'(CLEAR_DIAG_CYC - 1);
      end
   end

   // ***************************************************
   // diagnostic flags
   // ***************************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         diag_q <= 16'h0000;
      end else begin
         // clear on command end or new record, sets win
         if ((glob_q[GC_CLEAR_DIAG] && cmd_cnt_q == 32'h0000_0000) || trig_fire)
            diag_q <= 16'h0000; // R24 R14
         diag_q[13:8] <= ((glob_q[GC_CLEAR_DIAG] && cmd_cnt_q == 32'h0000_0000) || trig_fire
                         ? 6'h00 : diag_q[13:8]) | alarm_set_i; // R24
         if (glob_q[GC_SELF_TEST] && cmd_cnt_q == 32'h0000_0000)
            diag_q[DG_SELF] <= self_test_fail_i; // R18
         if (glob_q[GC_FLASH_TEST] && cmd_cnt_q == 32'h0000_0000)
            diag_q[DG_FLASH] <= flash_sum_fail_i; // R19
         if (accept && frame_i == ESCAPE_FRAME && capture_busy_i)
            diag_q[DG_ESCAPE] <= 1'b1; // R8
      end
   end

   // ***************************************************
   // writable registers
   // ***************************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         line_cfg_q   <= LINE_CFG_RST; // R10
         line_io_q    <= LINE_IO_RST;
         owner_q      <= OWNER_RST;
         alarm_ctrl_q <= 16'h0000;
         rec_ctrl_q   <= 16'h0000;
      end else if (is_write) begin
         unique case (frame_i.addr)
            ADDR_LINE_CFG:   line_cfg_q[7:0] <= {2'b00, frame_i.data[5:0]}; // R15 R16
            ADDR_LINE_IO:    line_io_q[1:0]  <= frame_i.data[1:0]; // R17
            7'h39:           line_io_q[9:8]  <= frame_i.data[1:0]; // R17
            ADDR_OWNER:      owner_q[7:0]    <= frame_i.data; // R22
            7'h5d:           owner_q[15:8]   <= frame_i.data; // R22
            ADDR_ALARM_CTRL: alarm_ctrl_q[7:0] <= frame_i.data;
            ADDR_REC_CTRL:   rec_ctrl_q[7:0] <= frame_i.data;
            default:         ;
         endcase
      end
   end

   // flash write counter
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         flash_write_counter_q <= 16'h0000;
      else if (flash_write_i)
         flash_write_counter_q <= flash_write_counter_q + 16'h0001; // R20
   end

   // ***************************************************
   // read path
   // ***************************************************
   always_comb begin
      unique case (frame_i.addr & 7'h7e)
         ADDR_FLASH_WRITE_COUNTER:  rd_mux = flash_write_counter_q;
         ADDR_LINE_CFG:   rd_mux = line_cfg_q;
         ADDR_LINE_IO:    rd_mux = {6'h00, line_io_q[9:8], 6'h00, line_in_q}; // R17
         ADDR_DIAG:       rd_mux = {diag_q[15:8], !busy, diag_q[6:0]}; // R7
         ADDR_ALARM_CTRL: rd_mux = alarm_ctrl_q;
         ADDR_REC_CTRL:   rd_mux = rec_ctrl_q;
         ADDR_LOT_FIRST:  rd_mux = LOT_FIRST; // R21
         ADDR_LOT_SECOND: rd_mux = LOT_SECOND; // R21
         ADDR_PART_CODE:  rd_mux = PART_CODE;
         ADDR_SERIAL:     rd_mux = SERIAL; // R21
         ADDR_OWNER:      rd_mux = owner_q; // R22
         default:         rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o         <= 16'h0000;
         rdata_valid_o   <= 1'b0;
         record_start_o  <= 1'b0;
         capture_abort_o <= 1'b0;
         sleep_o         <= 1'b0;
      end else begin
         rdata_valid_o   <= accept && !frame_i.wr;
         if (accept && !frame_i.wr)
            rdata_o <= rd_mux;
         record_start_o  <= trig_fire; // R11
         // escape only acts on a running capture
         capture_abort_o <= gated && frame_i == ESCAPE_FRAME && capture_busy_i; // R8 R9
         sleep_o         <= sleep_q;
      end
   end

   // ***************************************************
   // line drivers
   // ***************************************************
   always_comb begin
      logic act;
      act = 1'b0;
      drv = '0;
      for (int i = 0; i < 2; i++) begin
         act = 1'b0;
         unique case (line_fn(line_cfg_q, i))
            FN_GPIO: begin
               drv.oe[i] = line_io_q[i]; // R17
               drv.o[i]  = line_io_q[8 + i];
            end
            FN_ALARM: begin
               drv.oe[i] = 1'b1;
               if (alarm_ctrl_q[ALM_SPLIT] && line_fn(line_cfg_q, 1 - i) == FN_ALARM)
                  act = i == 1 ? |diag_q[13:11] : |diag_q[10:8]; // R13
               else
                  act = |diag_q[13:8]; // R12
               drv.o[i] = act ~^ line_cfg_q[i]; // R16
            end
            FN_TRIG: ;
            FN_BUSY: begin
               drv.oe[i] = 1'b1;
               drv.o[i]  = busy ~^ line_cfg_q[i]; // R10
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         line_o    <= 2'b00;
         line_oe_o <= 2'b00;
      end else begin
         line_o    <= drv.o;
         line_oe_o <= drv.oe;
      end
   end
endmodule

//--- rtl/sys_io_pkg.sv
// constants and carrier types for the system-tool block
// assumes a 16-bit serial command frame already deserialised upstream
package sys_io_pkg;
   // ***************************************************
   // register byte addresses
   // ***************************************************
   localparam logic [6:0] ADDR_FLASH_WRITE_COUNTER   = 7'h00;
   localparam logic [6:0] ADDR_LINE_CFG    = 7'h36;
   localparam logic [6:0] ADDR_LINE_IO     = 7'h38;
   localparam logic [6:0] ADDR_DIAG        = 7'h3c;
   localparam logic [6:0] ADDR_GLOB        = 7'h3e;
   localparam logic [6:0] ADDR_ALARM_CTRL  = 7'h34;
   localparam logic [6:0] ADDR_REC_CTRL    = 7'h1a;
   localparam logic [6:0] ADDR_LOT_FIRST   = 7'h52;
   localparam logic [6:0] ADDR_LOT_SECOND  = 7'h54;
   localparam logic [6:0] ADDR_PART_CODE   = 7'h56;
   localparam logic [6:0] ADDR_SERIAL      = 7'h58;
   localparam logic [6:0] ADDR_OWNER       = 7'h5c;
   // ***************************************************
   // reset values and special frames
   // ***************************************************
   localparam logic [15:0] LINE_CFG_RST    = 16'h000f;
   localparam logic [15:0] LINE_IO_RST     = 16'h0000;
   localparam logic [15:0] OWNER_RST       = 16'h0000;
   localparam logic [15:0] DIAG_READ_FRAME = 16'h3c00;
   localparam logic [15:0] ESCAPE_FRAME    = 16'he8e8;
   // ***************************************************
   // field positions
   // ***************************************************
   localparam int GC_POWER_DOWN = 1;
   localparam int GC_SELF_TEST  = 2;
   localparam int GC_CLEAR_DIAG = 4;
   localparam int GC_FLASH_TEST = 5;
   localparam int REC_AUTO_PD   = 7;
   localparam int ALM_SPLIT     = 6;
   localparam int DG_READY      = 7;
   localparam int DG_FLASH      = 6;
   localparam int DG_SELF       = 5;
   localparam int DG_ESCAPE     = 4;
   // ***************************************************
   // timing
   // ***************************************************
   localparam int CLK_NS         = 10;
   localparam int TRIG_MIN_NS    = 2600;
   localparam int TRIG_MIN_CYC   = (TRIG_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int CLEAR_DIAG_US  = 36;
   localparam int CLEAR_DIAG_CYC = CLEAR_DIAG_US * 1000 / CLK_NS;
   localparam int SELF_TEST_US   = 32900;
   localparam int SELF_TEST_CYC  = SELF_TEST_US * 1000 / CLK_NS;
   localparam int FLASH_TEST_US  = 5000;
   localparam int FLASH_TEST_CYC = FLASH_TEST_US * 1000 / CLK_NS;
   localparam logic [1:0] FN_GPIO = 2'b00;
   localparam logic [1:0] FN_ALARM = 2'b01;
   localparam logic [1:0] FN_TRIG = 2'b10;
   localparam logic [1:0] FN_BUSY = 2'b11;
   // serial command frame, bit 15 write flag
   typedef struct packed {
      logic       wr;
      logic [6:0] addr;
      logic [7:0] data;
   } frame_t;
   typedef struct packed {
      logic [1:0] o;
      logic [1:0] oe;
   } line_drive_t;
endpackage

//--- bench/sys_io_checker_props.sv
// port assertions for the system-tool block
// assumes binding onto sys_io_power_control, one clock domain
`timescale 1ns/10ps
module sys_io_checker
   import sys_io_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cs_n_i,
   input wire logic        frame_valid_i,
   input wire frame_t      frame_i,
   input wire logic [15:0] rdata_o,
   input wire logic        rdata_valid_o,
   input wire logic        capture_busy_i,
   input wire logic        record_done_i,
   input wire logic        record_start_o,
   input wire logic        capture_abort_o,
   input wire logic        sleep_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ****************
   // frame sequences
   // ****************
   sequence s_diag_rd;
      frame_valid_i && !sleep_o && frame_i == DIAG_READ_FRAME;
   endsequence
   sequence s_escape_busy;
      frame_valid_i && !sleep_o && frame_i == ESCAPE_FRAME && capture_busy_i;
   endsequence
   property p_diag_answer; s_diag_rd |=> rdata_valid_o; endproperty
   property p_busy_bit; s_diag_rd ##0 capture_busy_i |=> !rdata_o[DG_READY]; endproperty
   property p_escape; s_escape_busy |=> capture_abort_o; endproperty
   property p_abort_cause;
      capture_abort_o |-> $past(frame_valid_i) && $past(capture_busy_i) && $past(frame_i) == ESCAPE_FRAME;
   endproperty
   property p_sleep_cause;
      $rose(sleep_o) |-> ($past(frame_valid_i, 2) && $past(frame_i, 2) == 16'hbe02)
                         || $past(record_done_i) || $past(record_done_i, 2);
   endproperty
   property p_wake_cs; sleep_o && $fell(cs_n_i) |-> ##[1:2] !sleep_o; endproperty
   property p_asleep_deaf; sleep_o && frame_valid_i |=> !rdata_valid_o; endproperty
   property p_start_idle; record_start_o |-> !$past(capture_busy_i) && !$past(record_start_o); endproperty
   property p_read_cause; rdata_valid_o |-> $past(frame_valid_i) && !$past(frame_i.wr); endproperty
   a_diag_answer: assert property (p_diag_answer) else $error("status read not answered");
   a_busy_bit: assert property (p_busy_bit) else $error("ready bit set while busy");
   a_escape: assert property (p_escape) else $error("escape did not abort capture");
   a_abort_cause: assert property (p_abort_cause) else $error("abort without escape in capture");
   a_sleep_cause: assert property (p_sleep_cause) else $error("sleep entered without cause");
   a_wake_cs: assert property (p_wake_cs) else $error("select edge did not wake");
   a_asleep_deaf: assert property (p_asleep_deaf) else $error("frame answered while asleep");
   a_start_idle: assert property (p_start_idle) else $error("record start while busy");
   a_read_cause: assert property (p_read_cause) else $error("read data without read frame");
endmodule
bind sys_io_power_control sys_io_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
   .frame_valid_i(frame_valid_i), .frame_i(frame_i), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
   .capture_busy_i(capture_busy_i), .record_done_i(record_done_i), .record_start_o(record_start_o),
   .capture_abort_o(capture_abort_o), .sleep_o(sleep_o));

//--- bench/host_trigger_model.sv
// host side of the trigger line: one low-high-low pulse per request
// assumes the line idles low and is changed at the falling edge
`timescale 1ns/10ps
module host_trigger_model (
   input  wire logic       clk_i,
   input  wire logic       fire_i,
   input  wire logic [9:0] hold_i,
   output logic            line_o
);
   // high for hold_i cycles, then back low
   initial line_o = 1'b0;
   always begin
      @(posedge fire_i);
      @(negedge clk_i);
      line_o = 1'b1;
      repeat (hold_i) @(negedge clk_i);
      line_o = 1'b0;
   end
endmodule

//--- bench/sys_io_power_control_bench.sv
// self-checking bench for the system-tool block
// assumes sys_io_pkg, the trigger model and the bound checker
`timescale 1ns/10ps
module sys_io_power_control_bench;
   import sys_io_pkg::*;
   localparam logic [15:0] LOT_A = 16'h0a01; // arbitrary value
   localparam logic [15:0] LOT_B = 16'h0a02; // arbitrary value
   localparam logic [15:0] PART  = 16'h0c03; // arbitrary value
   localparam logic [15:0] SER   = 16'h0d04; // arbitrary value
   localparam logic [9:0]  TMIN  = 10'(TRIG_MIN_CYC);
   typedef struct packed {logic wr; logic [6:0] a; logic [15:0] d; logic [15:0] e;} row_t;
   logic clk_i, rst_i, cs_n_i, frame_valid_i, rdata_valid_o, capture_busy_i, record_done_i;
   logic record_start_o, capture_abort_o, flash_write_i, self_test_fail_i, flash_sum_fail_i;
   logic sleep_o, fire, trig_lvl;
   logic [15:0] rdata_o, v, w;
   logic [9:0]  hold;
   logic [5:0]  alarm_set_i;
   logic [1:0]  line_o, line_oe_o;
   frame_t      frame_i;
   int          n_errors, comparisons, n_starts, n_aborts;
   row_t rows [9] = '{'{0, ADDR_LINE_CFG, 0, LINE_CFG_RST}, '{0, ADDR_LINE_IO, 0, LINE_IO_RST},
      '{0, ADDR_OWNER, 0, OWNER_RST}, '{0, ADDR_LOT_FIRST, 0, LOT_A}, '{0, ADDR_LOT_SECOND, 0, LOT_B},
      '{0, ADDR_PART_CODE, 0, PART}, '{0, ADDR_SERIAL, 0, SER}, '{1, ADDR_OWNER, 16'hbeef, 16'hbeef},
      '{1, ADDR_PART_CODE, 16'h1111, PART}};
   sys_io_power_control #(.SELF_CYC(20), .FLASH_CYC(20), .LOT_FIRST(LOT_A), .LOT_SECOND(LOT_B),
      .PART_CODE(PART), .SERIAL(SER)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
      .frame_valid_i(frame_valid_i), .frame_i(frame_i), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
      .capture_busy_i(capture_busy_i), .record_done_i(record_done_i), .record_start_o(record_start_o),
      .capture_abort_o(capture_abort_o), .alarm_set_i(alarm_set_i), .flash_write_i(flash_write_i),
      .self_test_fail_i(self_test_fail_i), .flash_sum_fail_i(flash_sum_fail_i),
      .line_in_i({trig_lvl, 1'b0}), .line_o(line_o), .line_oe_o(line_oe_o), .sleep_o(sleep_o));
   host_trigger_model trig_u (.clk_i(clk_i), .fire_i(fire), .hold_i(hold), .line_o(trig_lvl));
   // ****************
   // clock, monitors, helpers
   // ****************
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (record_start_o === 1'b1) n_starts++;
      if (capture_abort_o === 1'b1) n_aborts++;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic send(input logic wr, input logic [6:0] a, input logic [7:0] d);
      @(negedge clk_i);
      frame_valid_i = 1'b1;
      frame_i = '{wr, a, d};
      @(negedge clk_i);
      frame_valid_i = 1'b0;
   endtask
   task automatic put16(input logic [6:0] a, input logic [15:0] d);
      send(1'b1, a, d[7:0]);
      send(1'b1, a + 7'd1, d[15:8]);
   endtask
   task automatic get16(input logic [6:0] a, output logic [15:0] r);
      send(1'b0, a, 8'h00);
      check("read answer", {15'd0, rdata_valid_o}, 16'h0001);
      r = rdata_o;
   endtask
   task automatic wait_ready;
      logic [15:0] r;
      int k;
      r = 16'h0000;
      for (k = 0; k < 3000 && r[DG_READY] !== 1'b1; k++) get16(ADDR_DIAG, r);
      check("ready bit", {15'd0, r[DG_READY]}, 16'h0001);
   endtask
   task automatic pulse(ref logic s, input int gap);
      @(negedge clk_i);
      s = 1'b1;
      @(negedge clk_i);
      s = 1'b0;
      repeat (gap) @(negedge clk_i);
   endtask
   task automatic trig(input logic [9:0] h);
      hold = h;
      fire = 1'b1;
      repeat (h + 10) @(negedge clk_i);
      fire = 1'b0;
   endtask
   task automatic wake;
      pulse(cs_n_i, 3);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // watchdog well beyond the expected run
   initial begin
      repeat (60000) @(posedge clk_i);
      n_errors++;
      stop_test();
   end
   // ****************
   // main sequence
   // ****************
   initial begin
      {rst_i, cs_n_i, frame_valid_i, capture_busy_i, record_done_i, flash_write_i} = 6'b100000;
      {self_test_fail_i, flash_sum_fail_i, fire, alarm_set_i, hold, frame_i} = '0;
      repeat (20) @(negedge clk_i);
      rst_i = 1'b0;
      @(negedge clk_i);
      check("line enable", {14'd0, line_oe_o}, 16'h0001);
      foreach (rows[i]) begin
         if (rows[i].wr) put16(rows[i].a, rows[i].d);
         get16(rows[i].a, v);
         check("register", v, rows[i].e);
      end
      $display("test registers done");
      put16(ADDR_LINE_CFG, 16'h002f);
      capture_busy_i = 1'b1;
      @(negedge clk_i);
      check("busy line", {14'd0, line_o}, 16'h0001);
      get16(ADDR_DIAG, v);
      check("busy bit", {15'd0, v[DG_READY]}, 16'h0000);
      send(1'b1, ADDR_OWNER, 8'h55);
      repeat (2) send(1'b1, 7'h68, 8'he8);
      @(negedge clk_i);
      check("aborts", n_aborts[15:0], 16'h0002);
      trig(TMIN);
      check("busy trigger", n_starts[15:0], 16'h0000);
      capture_busy_i = 1'b0;
      send(1'b1, 7'h68, 8'he8);
      @(negedge clk_i);
      check("idle escape", n_aborts[15:0], 16'h0002);
      get16(ADDR_OWNER, v);
      check("gated write", v, 16'hbeef);
      trig(TMIN);
      check("trigger start", n_starts[15:0], 16'h0001);
      $display("test busy done");
      send(1'b1, ADDR_GLOB, 8'h02);
      @(negedge clk_i);
      check("sleep", {15'd0, sleep_o}, 16'h0001);
      trig(TMIN);
      check("trigger wake", {15'd0, sleep_o}, 16'h0000);
      send(1'b1, ADDR_GLOB, 8'h02);
      wake();
      check("select wake", {15'd0, sleep_o}, 16'h0000);
      send(1'b1, ADDR_REC_CTRL, 8'h80);
      pulse(record_done_i, 3);
      check("auto sleep", {15'd0, sleep_o}, 16'h0001);
      wake();
      send(1'b1, ADDR_REC_CTRL, 8'h00);
      pulse(record_done_i, 3);
      check("stay awake", {15'd0, sleep_o}, 16'h0000);
      $display("test power done");
      put16(ADDR_LINE_CFG, 16'h0010);
      check("low alarm idle", {14'd0, line_o[1], line_oe_o[1]}, 16'h0003);
      put16(ADDR_LINE_CFG, 16'h0012);
      put16(ADDR_LINE_IO, 16'h0101);
      alarm_set_i = 6'h01;
      @(negedge clk_i);
      alarm_set_i = 6'h00;
      repeat (3) @(negedge clk_i);
      check("alarm and gpio", {12'd0, line_oe_o, line_o}, 16'h000f);
      send(1'b1, ADDR_GLOB, 8'h10);
      wait_ready();
      check("alarm clear", {15'd0, line_o[1]}, 16'h0000);
      put16(ADDR_LINE_CFG, 16'h0017);
      send(1'b1, ADDR_ALARM_CTRL, 8'h40);
      alarm_set_i = 6'h08;
      @(negedge clk_i);
      alarm_set_i = 6'h00;
      repeat (3) @(negedge clk_i);
      check("split alarm", {14'd0, line_o}, 16'h0002);
      send(1'b1, ADDR_GLOB, 8'h10);
      wait_ready();
      check("split clear", {14'd0, line_o}, 16'h0000);
      $display("test lines done");
      {self_test_fail_i, flash_sum_fail_i} = 2'b11;
      send(1'b1, ADDR_GLOB, 8'h04);
      wait_ready();
      send(1'b1, ADDR_GLOB, 8'h20);
      wait_ready();
      get16(ADDR_DIAG, v);
      check("test flags", {14'd0, v[DG_FLASH], v[DG_SELF]}, 16'h0003);
      get16(ADDR_FLASH_WRITE_COUNTER, w);
      repeat (3) pulse(flash_write_i, 0);
      get16(ADDR_FLASH_WRITE_COUNTER, v);
      check("flash count", v, w + 16'd3);
      $display("test diagnostics done");
      stop_test();
   end
endmodule
